// file: core/mcc_pkg.sv
package mcc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CSR = 8'h2C;
    localparam logic [7:0] ADDR_TONE = 8'h2D;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h2E;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h2F;
    localparam logic [7:0] RESET_VAL = 8'h00;

    // clock_control_status fields
    localparam int CSR_CLK_OUT_EN = 7;
    localparam int CSR_SLOW_PRE_HI = 6;
    localparam int CSR_SLOW_PRE_LO = 5;
    localparam int CSR_SLOW_MODE = 4;
    localparam int CSR_TB_HI = 3;
    localparam int CSR_TB_LO = 2;
    localparam int CSR_TO_IRQ_EN = 1;
    localparam int CSR_TO_FLAG = 0;

    // tone_control and interrupt register fields
    localparam int TONE_SEL_HI = 1;
    localparam int TONE_SEL_LO = 0;
    localparam int IRQ_TIMEOUT = 0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 100_000_000;
    localparam longint OSC_HZ = 8_000_000;
    localparam longint TB_RATIO0 = 16000;
    localparam longint TB_RATIO1 = 32000;
    localparam longint TB_RATIO2 = 80000;
    localparam longint TB_RATIO3 = 200000;
    localparam int TB_CYC0 = int'(TB_RATIO0 * CLK_HZ / OSC_HZ);
    localparam int TB_CYC1 = int'(TB_RATIO1 * CLK_HZ / OSC_HZ);
    localparam int TB_CYC2 = int'(TB_RATIO2 * CLK_HZ / OSC_HZ);
    localparam int TB_CYC3 = int'(TB_RATIO3 * CLK_HZ / OSC_HZ);
    localparam longint TONE_HZ0 = 2000;
    localparam longint TONE_HZ1 = 1000;
    localparam longint TONE_HZ2 = 500;
    localparam int TONE_HALF0 = int'(CLK_HZ / (2 * TONE_HZ0));
    localparam int TONE_HALF1 = int'(CLK_HZ / (2 * TONE_HZ1));
    localparam int TONE_HALF2 = int'(CLK_HZ / (2 * TONE_HZ2));

endpackage : mcc_pkg

// file: core/mcc_clock_ctrl.sv
`timescale 1ns/100ps
module mcc_clock_ctrl #(
    parameter int TB_CYC0 = mcc_pkg::TB_CYC0,
    parameter int TB_CYC1 = mcc_pkg::TB_CYC1,
    parameter int TB_CYC2 = mcc_pkg::TB_CYC2,
    parameter int TB_CYC3 = mcc_pkg::TB_CYC3,
    parameter int TONE_HALF0 = mcc_pkg::TONE_HALF0,
    parameter int TONE_HALF1 = mcc_pkg::TONE_HALF1,
    parameter int TONE_HALF2 = mcc_pkg::TONE_HALF2,
    parameter int TB_W = 22,
    parameter int TONE_W = 17
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // power mode
    input wire logic activeHalt,
    // clock outputs
    output logic cpuClkEn,
    output logic clkOutPin,
    output logic clkOutOe,
    // tone pin
    output logic tonePin,
    output logic toneOe,
    // interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (TB_CYC0 < 2 || TB_CYC1 < 2 || TB_CYC2 < 2 || TB_CYC3 < 2 ||
        TB_CYC3 >= (1 << TB_W) || TB_CYC0 >= (1 << TB_W) || TB_CYC1 >= (1 << TB_W) || TB_CYC2 >= (1 << TB_W))
    begin : g_bad_tb
        $error("time base counts do not fit the counter");
    end
    if (TONE_HALF0 < 2 || TONE_HALF1 < 2 || TONE_HALF2 < 2 ||
        TONE_HALF0 >= (1 << TONE_W) || TONE_HALF1 >= (1 << TONE_W) || TONE_HALF2 >= (1 << TONE_W))
    begin : g_bad_tone
        $error("tone half periods do not fit the counter");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic clkOutEn_q, clkOutEn_d;
    logic [1:0] slowPre_q, slowPre_d;
    logic slowMode_q, slowMode_d;
    logic [1:0] tbSel_q, tbSel_d;
    logic [1:0] tbAct_q, tbAct_d;
    logic toIrqEn_q, toIrqEn_d;
    logic toFlag_q, toFlag_d;
    logic [1:0] toneSel_q, toneSel_d;
    logic irqStat_q, irqStat_d;
    logic irqMask_q, irqMask_d;
    logic [TB_W-1:0] tbCnt_q, tbCnt_d;
    logic [TONE_W-1:0] toneCnt_q, toneCnt_d;
    logic tonePin_q, tonePin_d;
    logic [3:0] divCnt_q, divCnt_d;
    logic cpuEn_q, cpuEn_d;
    logic clkOut_q, clkOut_d;
    logic [7:0] rdData_q, rdData_d;

    logic wrCsr, wrTone, wrStat, wrMask, rdCsr;
    logic tbTerm;
    logic [TB_W-1:0] tbLast;
    logic [TONE_W-1:0] toneLast;
    logic [3:0] divMask;
    logic [7:0] csrView;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    always_comb
    begin
        wrCsr = regWrStb && regAddr == mcc_pkg::ADDR_CSR;
        wrTone = regWrStb && regAddr == mcc_pkg::ADDR_TONE;
        wrStat = regWrStb && regAddr == mcc_pkg::ADDR_IRQ_STAT;
        wrMask = regWrStb && regAddr == mcc_pkg::ADDR_IRQ_MASK;
        rdCsr = regRdStb && regAddr == mcc_pkg::ADDR_CSR;
        csrView = {clkOutEn_q, slowPre_q, slowMode_q, tbSel_q, toIrqEn_q, toFlag_q};
    end

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    always_comb
    begin
        case (tbAct_q)
            2'h0: tbLast = TB_W'(TB_CYC0 - 1);
            2'h1: tbLast = TB_W'(TB_CYC1 - 1);
            2'h2: tbLast = TB_W'(TB_CYC2 - 1);
            default: tbLast = TB_W'(TB_CYC3 - 1);
        endcase
        tbTerm = tbCnt_q >= tbLast;
        tbCnt_d = tbTerm ? '0 : tbCnt_q + 1'b1;
        // new selection only takes hold when the running period ends
        tbAct_d = tbTerm ? tbSel_q : tbAct_q;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_comb
    begin
        clkOutEn_d = clkOutEn_q;
        slowPre_d = slowPre_q;
        slowMode_d = slowMode_q;
        tbSel_d = tbSel_q;
        toIrqEn_d = toIrqEn_q;
        toneSel_d = toneSel_q;
        irqMask_d = irqMask_q;
        if (wrCsr)
        begin
            clkOutEn_d = regWrData[mcc_pkg::CSR_CLK_OUT_EN];
            slowPre_d = regWrData[mcc_pkg::CSR_SLOW_PRE_HI:mcc_pkg::CSR_SLOW_PRE_LO];
            slowMode_d = regWrData[mcc_pkg::CSR_SLOW_MODE];
            tbSel_d = regWrData[mcc_pkg::CSR_TB_HI:mcc_pkg::CSR_TB_LO];
            toIrqEn_d = regWrData[mcc_pkg::CSR_TO_IRQ_EN];
        end
        // reserved upper bits are not stored
        if (wrTone)
        begin
            toneSel_d = regWrData[mcc_pkg::TONE_SEL_HI:mcc_pkg::TONE_SEL_LO];
        end
        if (wrMask)
        begin
            irqMask_d = regWrData[mcc_pkg::IRQ_TIMEOUT];
        end
        // period end beats a clearing read in the same cycle
        toFlag_d = tbTerm ? 1'b1 : (rdCsr ? 1'b0 : toFlag_q);
        irqStat_d = tbTerm | (irqStat_q & ~(wrStat & regWrData[mcc_pkg::IRQ_TIMEOUT]));
        rdData_d = 8'h00;
        if (regRdStb)
        begin
            case (regAddr)
                mcc_pkg::ADDR_CSR: rdData_d = csrView;
                mcc_pkg::ADDR_TONE: rdData_d = {6'h00, toneSel_q};
                mcc_pkg::ADDR_IRQ_STAT: rdData_d = {7'h00, irqStat_q};
                mcc_pkg::ADDR_IRQ_MASK: rdData_d = {7'h00, irqMask_q};
                default: rdData_d = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // tone divider
    // ----------------------------------------------------------------
    always_comb
    begin
        case (toneSel_q)
            2'h1: toneLast = TONE_W'(TONE_HALF0 - 1);
            2'h2: toneLast = TONE_W'(TONE_HALF1 - 1);
            default: toneLast = TONE_W'(TONE_HALF2 - 1);
        endcase
        // runs regardless of active halt
        if (toneSel_q == 2'h0)
        begin
            toneCnt_d = '0;
            tonePin_d = 1'b0;
        end
        else if (toneCnt_q >= toneLast)
        begin
            toneCnt_d = '0;
            tonePin_d = ~tonePin_q;
        end
        else
        begin
            toneCnt_d = toneCnt_q + 1'b1;
            tonePin_d = tonePin_q;
        end
    end

    // ----------------------------------------------------------------
    // cpu clock prescaler and clock out
    // ----------------------------------------------------------------
    always_comb
    begin
        divMask = 4'((5'h02 << slowPre_q) - 5'h01);
        divCnt_d = divCnt_q + 4'h1;
        cpuEn_d = !slowMode_q || ((divCnt_q & divMask) == divMask);
        // clock out idles low in active halt to save power
        if (!clkOutEn_q || activeHalt)
        begin
            clkOut_d = 1'b0;
        end
        else if (cpuEn_q)
        begin
            clkOut_d = ~clkOut_q;
        end
        else
        begin
            clkOut_d = clkOut_q;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            clkOutEn_q <= mcc_pkg::RESET_VAL[mcc_pkg::CSR_CLK_OUT_EN];
            slowPre_q <= mcc_pkg::RESET_VAL[mcc_pkg::CSR_SLOW_PRE_HI:mcc_pkg::CSR_SLOW_PRE_LO];
            slowMode_q <= mcc_pkg::RESET_VAL[mcc_pkg::CSR_SLOW_MODE];
            tbSel_q <= mcc_pkg::RESET_VAL[mcc_pkg::CSR_TB_HI:mcc_pkg::CSR_TB_LO];
            tbAct_q <= mcc_pkg::RESET_VAL[mcc_pkg::CSR_TB_HI:mcc_pkg::CSR_TB_LO];
            toIrqEn_q <= mcc_pkg::RESET_VAL[mcc_pkg::CSR_TO_IRQ_EN];
            toFlag_q <= mcc_pkg::RESET_VAL[mcc_pkg::CSR_TO_FLAG];
            toneSel_q <= mcc_pkg::RESET_VAL[mcc_pkg::TONE_SEL_HI:mcc_pkg::TONE_SEL_LO];
            irqStat_q <= 1'b0;
            irqMask_q <= 1'b0;
            tbCnt_q <= '0;
            toneCnt_q <= '0;
            tonePin_q <= 1'b0;
            divCnt_q <= 4'h0;
            cpuEn_q <= 1'b0;
            clkOut_q <= 1'b0;
            rdData_q <= 8'h00;
        end
        else if (ce)
        begin
            clkOutEn_q <= clkOutEn_d;
            slowPre_q <= slowPre_d;
            slowMode_q <= slowMode_d;
            tbSel_q <= tbSel_d;
            tbAct_q <= tbAct_d;
            toIrqEn_q <= toIrqEn_d;
            toFlag_q <= toFlag_d;
            toneSel_q <= toneSel_d;
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            tbCnt_q <= tbCnt_d;
            toneCnt_q <= toneCnt_d;
            tonePin_q <= tonePin_d;
            divCnt_q <= divCnt_d;
            cpuEn_q <= cpuEn_d;
            clkOut_q <= clkOut_d;
            rdData_q <= rdData_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign regRdData = rdData_q;
    assign cpuClkEn = cpuEn_q;
    assign clkOutPin = clkOut_q;
    assign clkOutOe = clkOutEn_q && !activeHalt;
    assign tonePin = tonePin_q;
    assign toneOe = toneSel_q != 2'h0;
    assign irq = (irqStat_q && irqMask_q) || (toFlag_q && toIrqEn_q);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence csrReadSeq;
        ce && rdCsr && !tbTerm;
    endsequence

    sequence periodEndSeq;
        ce && tbTerm;
    endsequence

    toneOff_a: assert property (ce && toneSel_q == 2'h0 |=> !tonePin_q && toneCnt_q == '0)
        else $error("tone pin active while tone is off");
    tone2k_a: assert property (ce && toneSel_q == 2'h1 && !wrTone
        |=> toneCnt_q <= TONE_W'(TONE_HALF0 - 1))
        else $error("2 kHz half period exceeded");
    tone1k_a: assert property (ce && toneSel_q == 2'h2 && !wrTone
        |=> toneCnt_q <= TONE_W'(TONE_HALF1 - 1))
        else $error("1 kHz half period exceeded");
    tone500_a: assert property (ce && toneSel_q == 2'h3 && !wrTone
        |=> toneCnt_q <= TONE_W'(TONE_HALF2 - 1))
        else $error("500 Hz half period exceeded");
    toneToggle_a: assert property (ce && toneSel_q != 2'h0 && !wrTone && toneCnt_q == toneLast
        |=> tonePin_q != $past(tonePin_q) && toneCnt_q == '0)
        else $error("tone did not toggle at half period");
    haltTone_a: assert property (ce && activeHalt && toneSel_q != 2'h0 |=> toneCnt_q != $past(toneCnt_q))
        else $error("tone stalled in active halt");
    resetClear_a: assert property (disable iff (1'b0) !nrst |=> csrView == 8'h00 && toneSel_q == 2'h0)
        else $error("registers not cleared by reset");
    flagSet_a: assert property (periodEndSeq |=> toFlag_q && irqStat_q)
        else $error("timeout flag not set at period end");
    flagClr_a: assert property (csrReadSeq |=> !toFlag_q ##1 !toFlag_q || $past(tbTerm && ce))
        else $error("timeout flag not cleared by read");
    tbSwitch_a: assert property ($changed(tbAct_q) |-> $past(tbTerm && ce))
        else $error("time base switched mid period");
    tbBound_a: assert property (tbCnt_q <= tbLast)
        else $error("time base counter past its period");
    cpuFull_a: assert property (ce && !slowMode_q |=> cpuEn_q)
        else $error("cpu clock divided outside slow mode");
    cpuHalf_a: assert property (ce && slowMode_q && slowPre_q == 2'h0 && !wrCsr ##1 ce && slowMode_q
        |=> cpuEn_q != $past(cpuEn_q))
        else $error("slow mode divide by two broken");

    // ----------------------------------------------------------------
    // enable, bus, flag, tone and clock out checks
    // ----------------------------------------------------------------
    freezeCnt_a: assert property (!ce
        |=> $stable(toneCnt_q) && $stable(tbCnt_q) && $stable(divCnt_q))
        else $error("counters moved while clock enable low");
    freezeRegs_a: assert property (!ce
        |=> $stable(csrView) && $stable(toneSel_q) && $stable(irqStat_q))
        else $error("registers moved while clock enable low");
    rdIdle_a: assert property (ce && !regRdStb
        |=> regRdData == 8'h00)
        else $error("read data outside read cycle");
    statClr_a: assert property (ce && wrStat && regWrData[mcc_pkg::IRQ_TIMEOUT] && !tbTerm
        |=> !irqStat_q)
        else $error("status bit not cleared by write");
    flagHold_a: assert property (ce && !tbTerm && !rdCsr
        |=> toFlag_q == $past(toFlag_q))
        else $error("timeout flag changed without cause");
    toneHold_a: assert property (ce && toneSel_q != 2'h0 && toneCnt_q < toneLast
        |=> $stable(tonePin_q))
        else $error("tone pin moved inside half period");
    clkIdle_a: assert property (ce && (activeHalt || !clkOutEn_q)
        |=> !clkOut_q)
        else $error("clock out active while stopped");
    clkToggle_a: assert property (ce && clkOutEn_q && !activeHalt && cpuEn_q
        |=> clkOut_q != $past(clkOut_q))
        else $error("clock out missed a toggle");

endmodule : mcc_clock_ctrl

// file: sim/test_mcc_clock_ctrl.sv
`timescale 1ns/100ps
module test_mcc_clock_ctrl;
    localparam int HALF[3] = '{4, 6, 8};
    localparam int TBC[4] = '{20, 30, 40, 50};
    logic core_clk, nrst, ce, regWrStb, regRdStb, activeHalt;
    logic [7:0] regAddr, regWrData, regRdData;
    logic cpuClkEn, clkOutPin, clkOutOe, tonePin, toneOe, irq;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;

    mcc_clock_ctrl #(.TB_CYC0(TBC[0]), .TB_CYC1(TBC[1]), .TB_CYC2(TBC[2]), .TB_CYC3(TBC[3]),
        .TONE_HALF0(HALF[0]), .TONE_HALF1(HALF[1]), .TONE_HALF2(HALF[2])) dut (
        .core_clk(core_clk), .nrst(nrst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .activeHalt(activeHalt),
        .cpuClkEn(cpuClkEn), .clkOutPin(clkOutPin), .clkOutOe(clkOutOe), .tonePin(tonePin),
        .toneOe(toneOe), .irq(irq));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc <= cyc + 1;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic hang(input string what);
        num_errors++;
        $display("Error %s expected event seen timeout", what);
        print_verdict();
    endtask : hang

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrStb <= 1'b0;
        #1;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1;
        chk($sformatf("read %0h", a), {24'h0, exp}, {24'h0, regRdData});
    endtask : rdchk

    // cycle stamp of the next irq high, sampled after the edge
    task automatic wait_irq(output int t);
        int i;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge core_clk);
            #1;
            if (irq === 1'b1) break;
        end
        if (i == 2000) hang("irq");
        t = cyc;
    endtask : wait_irq

    // cycles until the tone pin changes level
    task automatic edge_wait(output int n);
        logic p;
        n = 0;
        #1;
        p = tonePin;
        while (tonePin === p)
        begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 500) hang("tone edge");
        end
    endtask : edge_wait

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int a = 8'h2C; a <= 8'h30; a++) rdchk(a[7:0], 8'h00);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_tone;
        int n;
        logic p0;
        for (int c = 1; c < 4; c++)
        begin
            wr(mcc_pkg::ADDR_TONE, c[7:0]);
            edge_wait(n);
            edge_wait(n);
            chk("tone half period", HALF[c-1], n);
            chk("tone enable", 1, {31'h0, toneOe});
        end
        wr(mcc_pkg::ADDR_TONE, 8'h03);
        rdchk(mcc_pkg::ADDR_TONE, 8'h03);
        wr(mcc_pkg::ADDR_CSR, 8'h80);
        chk("clock out enable", 1, {31'h0, clkOutOe});
        @(posedge core_clk);
        #1;
        p0 = clkOutPin;
        @(posedge core_clk);
        #1;
        chk("clock out toggle", {31'h0, ~p0}, {31'h0, clkOutPin});
        @(posedge core_clk);
        activeHalt <= 1'b1;
        edge_wait(n);
        edge_wait(n);
        chk("tone half in halt", HALF[2], n);
        chk("clock out in halt", 0, {31'h0, clkOutOe});
        chk("clock out pin in halt", 0, {31'h0, clkOutPin});
        wr(mcc_pkg::ADDR_TONE, 8'h00);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            #1;
            chk("tone off pin", 0, {30'h0, toneOe, tonePin});
        end
        activeHalt <= 1'b0;
        wr(mcc_pkg::ADDR_CSR, 8'h00);
        $display("test tone done");
    endtask : t_tone

    task automatic t_freeze;
        logic p0;
        int n;
        wr(mcc_pkg::ADDR_TONE, 8'h01);
        @(posedge core_clk);
        ce <= 1'b0;
        #1;
        p0 = tonePin;
        wr(mcc_pkg::ADDR_TONE, 8'h00);
        repeat (10)
        begin
            @(posedge core_clk);
            #1;
            chk("tone pin frozen", {31'h0, p0}, {31'h0, tonePin});
        end
        chk("tone enable frozen", 1, {31'h0, toneOe});
        @(posedge core_clk);
        ce <= 1'b1;
        edge_wait(n);
        edge_wait(n);
        chk("tone half after freeze", HALF[0], n);
        wr(mcc_pkg::ADDR_TONE, 8'h00);
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_slow;
        int n;
        for (int p = -1; p < 4; p++)
        begin
            wr(mcc_pkg::ADDR_CSR, (p < 0) ? 8'h00 : (8'h10 | (p[7:0] << 5)));
            @(posedge core_clk);
            n = 0;
            repeat (64)
            begin
                @(posedge core_clk);
                #1;
                if (cpuClkEn === 1'b1) n++;
            end
            chk("cpu clock pulses", (p < 0) ? 64 : (64 >> (p + 1)), n);
        end
        wr(mcc_pkg::ADDR_CSR, 8'h00);
        $display("test slow mode done");
    endtask : t_slow

    task automatic t_timebase;
        int t0, t1, prev;
        rdchk(mcc_pkg::ADDR_IRQ_MASK, 8'h00);
        wr(mcc_pkg::ADDR_CSR, 8'h02);
        @(posedge core_clk);
        regRdStb <= 1'b1;
        regAddr <= mcc_pkg::ADDR_CSR;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        wait_irq(t0);
        rdchk(mcc_pkg::ADDR_CSR, 8'h03);
        chk("irq after read", 0, {31'h0, irq});
        rdchk(mcc_pkg::ADDR_CSR, 8'h02);
        rdchk(mcc_pkg::ADDR_IRQ_STAT, 8'h01);
        wr(mcc_pkg::ADDR_IRQ_STAT, 8'h01);
        rdchk(mcc_pkg::ADDR_IRQ_STAT, 8'h00);
        wr(mcc_pkg::ADDR_CSR, 8'h00);
        repeat (30) @(posedge core_clk);
        #1;
        chk("irq masked", 0, {31'h0, irq});
        wr(mcc_pkg::ADDR_IRQ_MASK, 8'h01);
        wait_irq(t0);
        wr(mcc_pkg::ADDR_IRQ_STAT, 8'h01);
        wait_irq(t0);
        wr(mcc_pkg::ADDR_IRQ_STAT, 8'h01);
        prev = 0;
        for (int c = 0; c < 4; c++)
        begin
            wr(mcc_pkg::ADDR_CSR, c[7:0] << 2);
            wait_irq(t1);
            wr(mcc_pkg::ADDR_IRQ_STAT, 8'h01);
            chk("period before change", TBC[prev], t1 - t0);
            t0 = t1;
            wait_irq(t1);
            wr(mcc_pkg::ADDR_IRQ_STAT, 8'h01);
            chk("period after change", TBC[c], t1 - t0);
            t0 = t1;
            prev = c;
        end
        $display("test time base done");
    endtask : t_timebase

    task automatic t_rereset;
        wr(mcc_pkg::ADDR_CSR, 8'hFE);
        wr(mcc_pkg::ADDR_TONE, 8'h03);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk("tone enable after reset", 0, {31'h0, toneOe});
        chk("irq after reset", 0, {31'h0, irq});
        rdchk(mcc_pkg::ADDR_CSR, 8'h00);
        rdchk(mcc_pkg::ADDR_TONE, 8'h00);
        $display("test second reset done");
    endtask : t_rereset

    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        activeHalt = 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_tone();
        t_freeze();
        t_slow();
        t_timebase();
        t_rereset();
        print_verdict();
    end
endmodule : test_mcc_clock_ctrl
